// *** hdl/buck_sleep_cfg.sv ***
// Register bank for converter three sleep and converter four control one
//
// What this block does
// - Codes 000,110,111: sleep change slot 5,3,1
// - Codes 001..101: turn off in slot 5..1
// - Hardware enable: codes 001..101 pick sleep slot
// - Mode field selects conduction; resets hysteretic
// - Voltage 0.85V plus 25mV steps, saturates
// - Follower bit: converter four follows converter three
// - Follower bit writable only by configuration load
// - Clock invert bit inverts switching clock
// - Float bit: floating not discharged when off
// - Soft-start step length 0, 512us, 4.096ms, 32.768ms
`timescale 1ns/100ps
module buck_sleep_cfg
#(
	parameter int unsigned SS_STEP_A_CYC = buck_cfg_pkg::SS_STEP_A_CYC,
	parameter int unsigned SS_STEP_B_CYC = buck_cfg_pkg::SS_STEP_B_CYC,
	parameter int unsigned SS_STEP_C_CYC = buck_cfg_pkg::SS_STEP_C_CYC
)
(
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	input wire logic i_nv_load_we,
	input wire logic i_nv_load_buck4,
	input wire logic [15:0] i_nv_load_data,
	input wire logic i_buck3_hw_assigned,
	input wire logic i_buck3_enable,
	input wire logic i_buck4_enable,
	input wire logic i_switch_clk,
	output logic [2:0] o_buck3_sleep_slot,
	output logic o_buck3_sleep_off,
	output logic [1:0] o_buck3_sleep_mode,
	output logic [11:0] o_buck3_sleep_mv,
	output logic o_buck4_follow,
	output logic o_buck4_switch_clk,
	output logic o_buck4_discharge,
	output logic [1:0] o_buck4_ilim_step
);
	logic [15:0] buck3_sleep_control;
	logic [15:0] buck4_control_one;
	logic dphase_write;
	logic dphase_read;
	logic [31:0] dphase_addr;
	logic [1:0] enable_sync_a;
	logic [1:0] enable_sync_b;
	logic buck4_run;
	logic [2:0] next_slot;
	logic next_off;
	logic [11:0] next_mv;
	logic sw_write_buck3;
	logic sw_write_buck4;

	// ==========================================================
	// AHB-Lite slave: zero wait states, always OKAY
	assign o_hreadyout = 1'h1;
	assign o_hresp = 1'h0;

	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			dphase_write <= 1'h0;
			dphase_read <= 1'h0;
			dphase_addr <= 32'h00000000;
		end
		else if (i_hready)
		begin
			dphase_write <= i_hsel && i_htrans[1] && i_hwrite;
			dphase_read <= i_hsel && i_htrans[1] && !i_hwrite;
			dphase_addr <= i_haddr;
		end
	end

	assign sw_write_buck3 = dphase_write && (dphase_addr == buck_cfg_pkg::BUCK3_SLEEP_CONTROL_ADDR);
	assign sw_write_buck4 = dphase_write && (dphase_addr == buck_cfg_pkg::BUCK4_CONTROL_ONE_ADDR);

	// Unmapped and reserved bits read zero
	always_comb
	begin
		o_hrdata = 32'h00000000;
		if (dphase_read && dphase_addr == buck_cfg_pkg::BUCK3_SLEEP_CONTROL_ADDR)
			o_hrdata = {16'h0000, buck3_sleep_control};
		else if (dphase_read && dphase_addr == buck_cfg_pkg::BUCK4_CONTROL_ONE_ADDR)
			o_hrdata = {16'h0000, buck4_control_one};
	end

	// ==========================================================
	// Registers; configuration load wins over a software write
	// resets to hysteretic
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
			buck3_sleep_control <= buck_cfg_pkg::BUCK3_SLEEP_CONTROL_RESET;
		else if (i_nv_load_we && !i_nv_load_buck4)
			buck3_sleep_control <= i_nv_load_data & buck_cfg_pkg::BUCK3_RW_MASK;
		else if (sw_write_buck3)
			buck3_sleep_control <= i_hwdata[15:0] & buck_cfg_pkg::BUCK3_RW_MASK;
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
			buck4_control_one <= buck_cfg_pkg::BUCK4_CONTROL_ONE_RESET;
		else if (i_nv_load_we && i_nv_load_buck4)
			buck4_control_one <= i_nv_load_data & buck_cfg_pkg::BUCK4_NV_MASK;
		else if (sw_write_buck4)
			buck4_control_one <= (i_hwdata[15:0] & buck_cfg_pkg::BUCK4_SW_MASK)
				| (buck4_control_one & ~buck_cfg_pkg::BUCK4_SW_MASK);
	end

	// ==========================================================
	// Enable pins pass two flip-flops
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			enable_sync_a <= 2'h0;
			enable_sync_b <= 2'h0;
		end
		else
		begin
			enable_sync_a <= {i_buck4_enable, i_buck3_enable};
			enable_sync_b <= enable_sync_a;
		end
	end

	assign buck4_run = o_buck4_follow ? enable_sync_b[0] : enable_sync_b[1];

	// ==========================================================
	// Decode and outputs
	buck3_sleep_decode u_decode
	(
		.i_slot_code(buck3_sleep_control[buck_cfg_pkg::SLOT_LSB +: 3]),
		.i_hw_assigned(i_buck3_hw_assigned),
		.i_vsel_code(buck3_sleep_control[buck_cfg_pkg::VSEL_LSB +: 7]),
		.o_slot(next_slot),
		.o_turn_off(next_off),
		.o_mv(next_mv)
	);

	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			o_buck3_sleep_slot <= 3'h5;
			o_buck3_sleep_off <= 1'h0;
			o_buck3_sleep_mode <= buck_cfg_pkg::MODE_HYSTERETIC;
			o_buck3_sleep_mv <= buck_cfg_pkg::VOLT_BASE_MV;
		end
		else
		begin
			o_buck3_sleep_slot <= next_slot;
			o_buck3_sleep_off <= next_off;
			o_buck3_sleep_mode <= buck3_sleep_control[buck_cfg_pkg::MODE_LSB +: 2];
			o_buck3_sleep_mv <= next_mv;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			o_buck4_follow <= 1'h0;
			o_buck4_switch_clk <= 1'h0;
			o_buck4_discharge <= 1'h1;
		end
		else
		begin
			o_buck4_follow <= buck4_control_one[buck_cfg_pkg::FOLLOW_BIT];
			o_buck4_switch_clk <= i_switch_clk ^ buck4_control_one[buck_cfg_pkg::INVERT_BIT];
			// discharge only when off and not floating
			o_buck4_discharge <= !buck4_run && !buck4_control_one[buck_cfg_pkg::FLOAT_BIT];
		end
	end

	buck4_softstart
	#(
		.STEP_A_CYC(SS_STEP_A_CYC),
		.STEP_B_CYC(SS_STEP_B_CYC),
		.STEP_C_CYC(SS_STEP_C_CYC)
	)
	u_softstart
	(
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_enable(buck4_run),
		.i_step_sel(buck4_control_one[buck_cfg_pkg::SOFTSTART_LSB +: 2]),
		.o_ilim_step(o_buck4_ilim_step)
	);

	// ==========================================================
	// Assertions
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_reset);

	a_slot_transition: assert property (
		buck3_sleep_control[15:13] == 3'h6 |=> !o_buck3_sleep_off && o_buck3_sleep_slot == 3'h3)
		else $error("transition code 110 not slot 3");
	a_slot_disable: assert property (
		buck3_sleep_control[15:13] == 3'h1 && !i_buck3_hw_assigned
		|=> o_buck3_sleep_off && o_buck3_sleep_slot == 3'h5)
		else $error("disable code 001 not off in slot 5");
	a_slot_hw_sleep: assert property (
		buck3_sleep_control[15:13] == 3'h5 && i_buck3_hw_assigned
		|=> !o_buck3_sleep_off && o_buck3_sleep_slot == 3'h1)
		else $error("hardware sleep slot wrong");
	a_mode_reset: assert property (
		disable iff (1'h0) $fell(i_reset) |-> o_buck3_sleep_mode == 2'h3)
		else $error("sleep mode not hysteretic after reset");
	a_volt_saturate: assert property (
		buck3_sleep_control[6:0] > 7'h65 |=> o_buck3_sleep_mv == 12'hD48)
		else $error("voltage not saturated");
	a_volt_step: assert property (
		buck3_sleep_control[6:0] == 7'h01 |=> o_buck3_sleep_mv == 12'h36B)
		else $error("voltage step not 25mV");
	a_follow_enable: assert property (
		o_buck4_follow && !enable_sync_b[0] |=> o_buck4_ilim_step == 2'h0)
		else $error("follower not using converter three enable");
	a_follow_readonly: assert property (
		sw_write_buck4 && !i_nv_load_we |=> $stable(buck4_control_one[13]))
		else $error("software changed follower bit");
	a_clock_invert: assert property (
		buck4_control_one[12] |=> o_buck4_switch_clk != $past(i_switch_clk))
		else $error("switching clock not inverted");
	a_float_hold: assert property (
		buck4_control_one[7] |=> !o_buck4_discharge)
		else $error("floating output discharged");
	a_softstart_immediate: assert property (
		buck4_run && buck4_control_one[5:4] == 2'h0 && $stable(buck4_control_one)
		##1 buck4_run |-> o_buck4_ilim_step == 2'h3)
		else $error("immediate start not at full limit");
	a_slot_code_zero: assert property (
		buck3_sleep_control[15:13] == 3'h0 |=> !o_buck3_sleep_off && o_buck3_sleep_slot == 3'h5)
		else $error("transition code 000 not slot 5");
	a_slot_code_seven: assert property (
		buck3_sleep_control[15:13] == 3'h7 |=> !o_buck3_sleep_off && o_buck3_sleep_slot == 3'h1)
		else $error("transition code 111 not slot 1");
	a_slot_off_mid: assert property (
		buck3_sleep_control[15:13] == 3'h3 && !i_buck3_hw_assigned
		|=> o_buck3_sleep_off && o_buck3_sleep_slot == 3'h3)
		else $error("disable code 011 not off in slot 3");
	a_slot_off_last: assert property (
		buck3_sleep_control[15:13] == 3'h5 && !i_buck3_hw_assigned
		|=> o_buck3_sleep_off && o_buck3_sleep_slot == 3'h1)
		else $error("disable code 101 not off in slot 1");
	a_slot_hw_first: assert property (
		buck3_sleep_control[15:13] == 3'h1 && i_buck3_hw_assigned
		|=> !o_buck3_sleep_off && o_buck3_sleep_slot == 3'h5)
		else $error("hardware sleep code 001 not slot 5");
	a_slot_hw_mid: assert property (
		buck3_sleep_control[15:13] == 3'h3 && i_buck3_hw_assigned
		|=> !o_buck3_sleep_off && o_buck3_sleep_slot == 3'h3)
		else $error("hardware sleep code 011 not slot 3");
	a_mode_follows_field: assert property (
		1'h1 |=> o_buck3_sleep_mode == $past(buck3_sleep_control[9:8]))
		else $error("sleep mode output not the field");
	a_volt_base: assert property (
		buck3_sleep_control[6:0] == 7'h00 |=> o_buck3_sleep_mv == 12'h352)
		else $error("voltage code 00 not 850 mV");
	a_buck3_sw_write: assert property (
		sw_write_buck3 && !i_nv_load_we
		|=> buck3_sleep_control == ($past(i_hwdata[15:0]) & buck_cfg_pkg::BUCK3_RW_MASK))
		else $error("software write to sleep control lost");
	a_follow_mirrors_bit: assert property (
		1'h1 |=> o_buck4_follow == $past(buck4_control_one[13]))
		else $error("follower output not the register bit");
	a_follow_nv_load: assert property (
		i_nv_load_we && i_nv_load_buck4
		|=> buck4_control_one[13] == $past(i_nv_load_data[13]))
		else $error("configuration load did not set follower bit");
	a_clock_normal: assert property (
		!buck4_control_one[12] |=> o_buck4_switch_clk == $past(i_switch_clk))
		else $error("switching clock not in normal phase");
	a_discharge_when_off: assert property (
		!buck4_control_one[7] && !buck4_run |=> o_buck4_discharge)
		else $error("disabled output not discharged");
	a_discharge_when_run: assert property (
		buck4_run |=> !o_buck4_discharge)
		else $error("running output discharged");
	a_softstart_idle: assert property (
		!buck4_run |=> o_buck4_ilim_step == 2'h0)
		else $error("soft-start not at first step while off");
	a_softstart_first_step: assert property (
		$rose(buck4_run) && buck4_control_one[5:4] != 2'h0 |=> o_buck4_ilim_step == 2'h0)
		else $error("timed soft-start skipped its first step");

	c_sleep_off: cover property (o_buck3_sleep_off);
	c_follow_on: cover property (o_buck4_follow);
	c_softstart_full: cover property (buck4_control_one[5:4] == 2'h1 && o_buck4_ilim_step == 2'h3);
	c_volt_top: cover property (o_buck3_sleep_mv == 12'hD48);
	c_hw_sleep_entry: cover property (i_buck3_hw_assigned && o_buck3_sleep_slot == 3'h1);
endmodule

// *** hdl/buck_cfg_pkg.sv ***
// Constants for the buck sleep and follower configuration bank
package buck_cfg_pkg;
	// ==========================================================
	// Register map: printed offsets are indices, byte address is 4x
	localparam logic [15:0] BUCK3_SLEEP_CONTROL_IDX = 16'h4063;
	localparam logic [15:0] BUCK4_CONTROL_ONE_IDX = 16'h4064;
	localparam logic [31:0] BUCK3_SLEEP_CONTROL_ADDR = {14'h0000, BUCK3_SLEEP_CONTROL_IDX, 2'h0};
	localparam logic [31:0] BUCK4_CONTROL_ONE_ADDR = {14'h0000, BUCK4_CONTROL_ONE_IDX, 2'h0};
	// ==========================================================
	// Field positions
	localparam int SLOT_LSB = 13;
	localparam int MODE_LSB = 8;
	localparam int VSEL_LSB = 0;
	localparam int FOLLOW_BIT = 13;
	localparam int INVERT_BIT = 12;
	localparam int FLOAT_BIT = 7;
	localparam int SOFTSTART_LSB = 4;
	localparam logic [15:0] BUCK3_RW_MASK = 16'hE37F;
	localparam logic [15:0] BUCK4_SW_MASK = 16'h10B0;
	localparam logic [15:0] BUCK4_NV_MASK = 16'h30B0;
	// ==========================================================
	// Reset values
	localparam logic [15:0] BUCK3_SLEEP_CONTROL_RESET = 16'h0300;
	localparam logic [15:0] BUCK4_CONTROL_ONE_RESET = 16'h0010;
	// ==========================================================
	// Encodings
	typedef enum logic [1:0]
	{
		MODE_FORCED_CCM = 2'h0,
		MODE_AUTO_SKIP = 2'h1,
		MODE_LINEAR = 2'h2,
		MODE_HYSTERETIC = 2'h3
	} conduction_mode_t;
	localparam logic [6:0] VSEL_MAX_CODE = 7'h65;
	localparam logic [11:0] VOLT_BASE_MV = 12'h352;
	localparam logic [11:0] VOLT_STEP_MV = 12'h019;
	localparam logic [11:0] VOLT_MAX_MV = 12'hD48;
	localparam logic [1:0] ILIM_FULL = 2'h3;
	// ==========================================================
	// Timing at a 20 ns clock; least times round up
	localparam int CLK_PERIOD_NS = 20;
	localparam int SS_STEP_A_NS = 512000;
	localparam int SS_STEP_B_NS = 4096000;
	localparam int SS_STEP_C_NS = 32768000;
	localparam int SS_STEP_A_CYC = (SS_STEP_A_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SS_STEP_B_CYC = (SS_STEP_B_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SS_STEP_C_CYC = (SS_STEP_C_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// *** hdl/buck3_sleep_decode.sv ***
// Decoder of the sleep timeslot code and sleep voltage code
`timescale 1ns/100ps
module buck3_sleep_decode
(
	input wire logic [2:0] i_slot_code,
	input wire logic i_hw_assigned,
	input wire logic [6:0] i_vsel_code,
	output logic [2:0] o_slot,
	output logic o_turn_off,
	output logic [11:0] o_mv
);
	logic [6:0] vsel_clamped;

	always_comb
	begin
		o_turn_off = 1'h0;
		unique case (i_slot_code)
			3'h0: o_slot = 3'h5;
			3'h6: o_slot = 3'h3;
			3'h7: o_slot = 3'h1;
			default:
			begin
				o_slot = 3'h6 - i_slot_code;
				o_turn_off = ~i_hw_assigned;
			end
		endcase
	end

	assign vsel_clamped = (i_vsel_code > buck_cfg_pkg::VSEL_MAX_CODE) ?
		buck_cfg_pkg::VSEL_MAX_CODE + 7'h01 : i_vsel_code;
	assign o_mv = buck_cfg_pkg::VOLT_BASE_MV + 12'(buck_cfg_pkg::VOLT_STEP_MV * {5'h00, vsel_clamped});
endmodule

// *** hdl/buck4_softstart.sv ***
// Soft-start sequencer stepping the current limit of converter four
`timescale 1ns/100ps
module buck4_softstart
#(
	parameter int unsigned STEP_A_CYC = 25600,
	parameter int unsigned STEP_B_CYC = 204800,
	parameter int unsigned STEP_C_CYC = 1638400
)
(
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_enable,
	input wire logic [1:0] i_step_sel,
	output logic [1:0] o_ilim_step
);
	logic [31:0] step_len;
	logic [31:0] count;

	always_comb
	begin
		unique case (i_step_sel)
			2'h1: step_len = 32'(STEP_A_CYC);
			2'h2: step_len = 32'(STEP_B_CYC);
			2'h3: step_len = 32'(STEP_C_CYC);
			default: step_len = 32'h00000001;
		endcase
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_reset || !i_enable)
		begin
			o_ilim_step <= 2'h0;
			count <= 32'h00000000;
		end
		else if (o_ilim_step != buck_cfg_pkg::ILIM_FULL)
		begin
			if (i_step_sel == 2'h0)
				o_ilim_step <= buck_cfg_pkg::ILIM_FULL;
			else if (count >= step_len - 32'h00000001)
			begin
				o_ilim_step <= o_ilim_step + 2'h1;
				count <= 32'h00000000;
			end
			else
				count <= count + 32'h00000001;
		end
	end
endmodule

// *** sim/tb.sv ***
// Self-checking testbench for the buck sleep and follower register bank
`timescale 1ns/100ps
module tb;
	logic i_mclk = 1'h0;
	logic i_reset = 1'h1;
	logic hsel = 1'h0;
	logic hwrite = 1'h0;
	logic nv_we = 1'h0;
	logic nv_b4 = 1'h0;
	logic hw_as = 1'h0;
	logic en3 = 1'h0;
	logic en4 = 1'h0;
	logic sw_clk = 1'h1;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [15:0] nv_data = 16'h0;
	logic [31:0] hrdata, rd_q, rdata;
	logic hreadyout, hresp, follow, sclk_o, dis, off;
	logic [2:0] slot;
	logic [1:0] mode, ilim;
	logic [11:0] mv;
	logic [2:0] es [8] = '{3'h5, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h3, 3'h1};
	logic [7:0] eo = 8'h3E;
	logic [6:0] vc [5] = '{7'h00, 7'h01, 7'h65, 7'h66, 7'h7F};
	int n_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	int n;
	localparam logic [31:0] A3 = buck_cfg_pkg::BUCK3_SLEEP_CONTROL_ADDR;
	localparam logic [31:0] A4 = buck_cfg_pkg::BUCK4_CONTROL_ONE_ADDR;

	buck_sleep_cfg #(.SS_STEP_A_CYC(4), .SS_STEP_B_CYC(6), .SS_STEP_C_CYC(8)) buck_sleep_cfg_i
	(
		.i_mclk(i_mclk), .i_reset(i_reset), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
		.i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
		.i_nv_load_we(nv_we), .i_nv_load_buck4(nv_b4), .i_nv_load_data(nv_data),
		.i_buck3_hw_assigned(hw_as), .i_buck3_enable(en3), .i_buck4_enable(en4),
		.i_switch_clk(sw_clk), .o_buck3_sleep_slot(slot), .o_buck3_sleep_off(off),
		.o_buck3_sleep_mode(mode), .o_buck3_sleep_mv(mv), .o_buck4_follow(follow),
		.o_buck4_switch_clk(sclk_o), .o_buck4_discharge(dis), .o_buck4_ilim_step(ilim)
	);

	always #10 i_mclk = ~i_mclk;
	// Switching clock reference toggles every cycle
	always @(posedge i_mclk) sw_clk <= ~sw_clk;
	// Read data as seen by the master at the data-phase end edge
	always @(posedge i_mclk) rd_q <= hrdata;
	always @(posedge i_mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_errors++;
			final_report();
		end
	end

	// ==========================================================
	// Tasks
	task automatic final_report();
		$display("tests %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge i_mclk); while (hreadyout !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge i_mclk); while (hreadyout !== 1'h1);
		#1 rdata = rd_q;
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] e, input string nm);
		bus(1'h0, a, 32'h0);
		chk(nm, e, rdata);
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask
	task automatic wait_n(input int k);
		repeat (k) @(posedge i_mclk);
		#1;
	endtask
	task automatic nv_load(input logic b, input logic [15:0] d);
		@(posedge i_mclk);
		nv_we <= 1'h1;
		nv_b4 <= b;
		nv_data <= d;
		@(posedge i_mclk);
		nv_we <= 1'h0;
		wait_n(3);
	endtask
	task automatic set_en4(input logic v);
		@(posedge i_mclk);
		en4 <= v;
		wait_n(1);
	endtask
	task automatic ss(input logic [1:0] c, input int e);
		bus(1'h1, A4, {26'h0, c, 4'h0});
		set_en4(1'h0);
		wait_n(4);
		set_en4(1'h1);
		n = 0;
		while (ilim !== 2'h1 && n < 50) begin wait_n(1); n++; end
		n = 0;
		while (ilim === 2'h1 && n < 50) begin wait_n(1); n++; end
		chk("ss step length", e, n);
		chk("ss next step", 32'h2, {30'h0, ilim});
	endtask

	// ==========================================================
	// Tests
	initial
	begin
		repeat (2) @(posedge i_mclk);
		i_reset <= 1'h0;
		@(posedge i_mclk);
		rd(A3, 32'h0300, "buck3 reset");
		rd(A4, 32'h0010, "buck4 reset");
		chk("mv reset", 32'h352, {20'h0, mv});
		rd(32'h0, 32'h0, "unmapped");
		bus(1'h1, A3, 32'hFFFF_FFFF);
		rd(A3, {16'h0, buck_cfg_pkg::BUCK3_RW_MASK}, "buck3 rw bits");
		$display("test reset and map done");
		for (int h = 0; h < 2; h++)
			for (int c = 0; c < 8; c++)
			begin
				hw_as <= h[0];
				bus(1'h1, A3, {16'h0, c[2:0], 13'h0300});
				wait_n(3);
				chk("slot", {29'h0, es[c]}, {29'h0, slot});
				chk("off", {31'h0, eo[c] & ~h[0]}, {31'h0, off});
			end
		for (int m = 0; m < 4; m++)
		begin
			bus(1'h1, A3, {22'h0, m[1:0], 8'h00});
			wait_n(3);
			chk("mode", m, {30'h0, mode});
		end
		for (int i = 0; i < 5; i++)
		begin
			bus(1'h1, A3, {25'h0, vc[i]});
			wait_n(3);
			chk("mv", (vc[i] > 7'h65) ? 32'hD48 : 32'h352 + vc[i] * 32'h19, {20'h0, mv});
		end
		$display("test buck3 fields done");
		ss(2'h1, 4);
		ss(2'h2, 6);
		ss(2'h3, 8);
		bus(1'h1, A4, 32'h0);
		set_en4(1'h0);
		wait_n(4);
		set_en4(1'h1);
		wait_n(2);
		chk("ss immediate", 32'h3, {30'h0, ilim});
		$display("test softstart done");
		bus(1'h1, A4, 32'hFFFF_FFFF);
		rd(A4, {16'h0, buck_cfg_pkg::BUCK4_SW_MASK}, "buck4 sw write");
		wait_n(3);
		chk("invert", {31'h0, sw_clk}, {31'h0, sclk_o});
		bus(1'h1, A4, 32'h0);
		set_en4(1'h0);
		wait_n(4);
		chk("normal", {31'h0, ~sw_clk}, {31'h0, sclk_o});
		chk("discharge", 32'h1, {31'h0, dis});
		bus(1'h1, A4, 32'h80);
		wait_n(3);
		chk("float", 32'h0, {31'h0, dis});
		$display("test buck4 fields done");
		nv_load(1'h1, 16'h2000);
		rd(A4, 32'h2000, "follower load");
		chk("follow", 32'h1, {31'h0, follow});
		set_en4(1'h1);
		wait_n(4);
		chk("follow ignores own enable", 32'h0, {30'h0, ilim});
		@(posedge i_mclk);
		en3 <= 1'h1;
		wait_n(6);
		chk("follow ilim", 32'h3, {30'h0, ilim});
		bus(1'h1, A4, 32'h0);
		rd(A4, 32'h2000, "follower sw write");
		nv_load(1'h1, 16'h0000);
		chk("follow off", 32'h0, {31'h0, follow});
		$display("test follower done");
		final_report();
	end
endmodule
